// ===== rtl/pcw_consts.svh
// Constants for the PLL control wrapper: register indices, fields, reset values, timing
//Contract
//R1 - Lock output is high while the loop is locked; the user synchronises it.
//R2 - General loop reset clears the loop but keeps the pre-divider state.
//R3 - Full reset clears the loop and the pre-divider.
//R4 - Output b divider reset clears only the output b divider.
//R5 - Output c divider reset clears only the output c divider.
//R6 - Standby powers the loop down; no output gives a valid clock.
//R7 - One primary and three secondary outputs, each with its own phase shift.
//R8 - Primary output toggles only while its gate input is high.
//R9 - Secondary gates act only while port control of outputs is active.
//R10 - Phase source output tells whether phase comes from ports or registers.
//R11 - Settings bus transfers happen on edges of the settings bus clock.
//R12 - Settings bus reset idles only the bus logic, never stored settings.
//R13 - User presents a 5-bit address for every access.
//R14 - Write and read data are each 8 bits wide.
//R15 - User starts an access with strobe, address valid at the same time.
//R16 - Write enable high means write, low means read, during strobe.
//R17 - Acknowledge marks access completion; read data valid with acknowledge.
//R18 - User holds request stable until acknowledge, then drops strobe.
`ifndef PCW_CONSTS_SVH
`define PCW_CONSTS_SVH

`define PCW_ADDR_W 5
`define PCW_DATA_W 8
`define PCW_NUM_REGS 32
`define PCW_NUM_OUTS 4

`define PCW_REG_DIV0 5'h00
`define PCW_REG_PHASE0 5'h04
`define PCW_REG_CTRL 5'h08
`define PCW_REG_PREDIV 5'h09
`define PCW_REG_STATUS 5'h0a

`define PCW_CTRL_PHASE_REG_BIT 0
`define PCW_CTRL_PORT_GATE_BIT 1
`define PCW_STATUS_LOCK_BIT 0
`define PCW_STATUS_STDBY_BIT 1

`define PCW_DIV_RESET 8'h01
`define PCW_CTRL_RESET 8'h02
`define PCW_PREDIV_RESET 8'h01

`define PCW_CLOCK_NS 10
`define PCW_LOCK_TIME_NS 1000
`define PCW_LOCK_CYCLES ((`PCW_LOCK_TIME_NS + `PCW_CLOCK_NS - 1) / `PCW_CLOCK_NS)

`endif

// ===== rtl/pcw_pkg.sv
// Types shared by the PLL control wrapper modules
`default_nettype none
package pcw_pkg;
	typedef enum logic [2:0] {
		PCW_BUS_IDLE = 3'b001,
		PCW_BUS_ACK = 3'b010,
		PCW_BUS_DONE = 3'b100
	} pcw_bus_e;

	typedef logic [7:0] pcw_byte_t;

	typedef struct packed {
		logic strobe;
		logic write;
		logic [4:0] addr;
		pcw_byte_t wdata;
	} pcw_bus_req_s;

	typedef struct packed {
		pcw_byte_t cnt;
		logic tog;
		logic clk;
	} pcw_div_s;

	typedef struct packed {
		pcw_bus_e bus;
		logic bclk;
		logic ack;
		pcw_byte_t rdata;
		logic [31:0][7:0] regs;
		pcw_byte_t pre_cnt;
		logic [15:0] lock_cnt;
		logic locked;
	} pcw_top_s;
endpackage
`default_nettype wire

// ===== rtl/pcw_out_div.sv
// One output clock divider with phase start, local reset and gated output
`default_nettype none
module pcw_out_div (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic run_i,
	input wire logic div_rst_i,
	input wire logic gate_i,
	input wire pcw_pkg::pcw_byte_t ratio_i,
	input wire pcw_pkg::pcw_byte_t phase_i,
	output logic clk_o
);
	import pcw_pkg::*;

	pcw_div_s s_q;
	pcw_div_s s_d;

	always_comb
	begin
		s_d = s_q;
		if (!run_i || div_rst_i)
		begin
			// Phase offset is the counter start, so outputs realign on reset
			s_d.cnt = (phase_i <= ratio_i) ? phase_i : 8'h00;
			s_d.tog = 1'b0;
		end
		else if (s_q.cnt >= ratio_i)
		begin
			s_d.cnt = 8'h00;
			s_d.tog = ~s_q.tog;
		end
		else
		begin
			s_d.cnt = s_q.cnt + 8'h01;
		end
		// Gate registered to keep the output glitch free
		s_d.clk = s_d.tog & gate_i & run_i & ~div_rst_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign clk_o = s_q.clk;
endmodule
`default_nettype wire

// ===== rtl/pcw_top.sv
// PLL control wrapper: resets, standby, lock, output gating and settings bus
`include "pcw_consts.svh"
`default_nettype none
module pcw_top #(
	parameter int LOCK_CYCLES = `PCW_LOCK_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic loop_reset_i,
	input wire logic full_reset_with_prediv_i,
	input wire logic out_b_divider_reset_i,
	input wire logic out_c_divider_reset_i,
	input wire logic standby_i,
	input wire logic primary_out_gate_i,
	input wire logic secondary_a_gate_i,
	input wire logic secondary_b_gate_i,
	input wire logic secondary_c_gate_i,
	input wire logic [3:0][7:0] phase_port_i,
	input wire logic settings_bus_clock_i,
	input wire logic settings_bus_reset_i,
	input wire logic settings_bus_strobe_i,
	input wire logic settings_bus_write_i,
	input wire logic [`PCW_ADDR_W-1:0] settings_bus_addr_i,
	input wire pcw_pkg::pcw_byte_t settings_bus_wdata_i,
	output pcw_pkg::pcw_byte_t settings_bus_rdata_o,
	output logic settings_bus_ack_o,
	output logic lock_o,
	output logic phase_source_indicator_o,
	output logic primary_out_clock_o,
	output logic secondary_out_clock_a_o,
	output logic secondary_out_clock_b_o,
	output logic secondary_out_clock_c_o
);
	import pcw_pkg::*;

	pcw_top_s s_q;
	pcw_top_s s_d;
	pcw_bus_req_s req;
	logic bclk_rise;
	logic loop_rst;
	logic run;
	logic port_gate;
	logic [3:0] gate;
	logic [3:0] div_rst;
	logic [3:0] clk_out;
	logic [3:0][7:0] phase_sel;

	assign req = '{strobe: settings_bus_strobe_i, write: settings_bus_write_i,
		addr: settings_bus_addr_i, wdata: settings_bus_wdata_i};
	assign bclk_rise = settings_bus_clock_i & ~s_q.bclk; // [R11]
	assign loop_rst = loop_reset_i | full_reset_with_prediv_i;
	assign run = s_q.locked & ~standby_i & ~loop_rst; // [R6]
	assign port_gate = s_q.regs[`PCW_REG_CTRL][`PCW_CTRL_PORT_GATE_BIT];

	always_comb
	begin
		s_d = s_q;
		s_d.bclk = settings_bus_clock_i;
		// Pre-divider keeps its count through the general loop reset
		if (full_reset_with_prediv_i) // [R3]
		begin
			s_d.pre_cnt = 8'h00;
		end
		else if (s_q.pre_cnt >= s_q.regs[`PCW_REG_PREDIV])
		begin
			s_d.pre_cnt = 8'h00;
		end
		else
		begin
			s_d.pre_cnt = s_q.pre_cnt + 8'h01;
		end
		if (loop_rst || standby_i) // [R2] [R3] [R6]
		begin
			s_d.lock_cnt = 16'h0000;
			s_d.locked = 1'b0;
		end
		else if (s_q.lock_cnt >= 16'(LOCK_CYCLES))
		begin
			s_d.locked = 1'b1; // [R1]
		end
		else
		begin
			s_d.lock_cnt = s_q.lock_cnt + 16'h0001;
		end
		if (settings_bus_reset_i)
		begin
			// Bus logic only; settings stay as written
			s_d.bus = PCW_BUS_IDLE; // [R12]
			s_d.ack = 1'b0;
		end
		else if (bclk_rise)
		begin
			unique case (s_q.bus)
				PCW_BUS_IDLE:
				begin
					if (req.strobe) // [R15]
					begin
						if (req.write && req.addr != `PCW_REG_STATUS) // [R16]
						begin
							s_d.regs[req.addr] = req.wdata; // [R14]
						end
						else if (req.addr == `PCW_REG_STATUS)
						begin
							s_d.rdata = {6'h00, standby_i, s_q.locked};
						end
						else
						begin
							s_d.rdata = s_q.regs[req.addr];
						end
						s_d.ack = 1'b1; // [R17]
						s_d.bus = PCW_BUS_ACK;
					end
				end
				PCW_BUS_ACK:
				begin
					s_d.ack = 1'b0;
					s_d.bus = PCW_BUS_DONE;
				end
				PCW_BUS_DONE:
				begin
					// Wait for strobe release so one access is taken once
					if (!req.strobe) // [R18]
					begin
						s_d.bus = PCW_BUS_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			s_q.bus <= PCW_BUS_IDLE;
			// High after reset, so a bus clock already high is not taken as a rise
			s_q.bclk <= 1'b1;
			s_q.ack <= 1'b0;
			s_q.rdata <= 8'h00;
			for (int i = 0; i < `PCW_NUM_REGS; i++)
			begin
				s_q.regs[i] <= 8'h00;
			end
			for (int i = 0; i < `PCW_NUM_OUTS; i++)
			begin
				s_q.regs[`PCW_REG_DIV0 + i] <= `PCW_DIV_RESET;
			end
			s_q.regs[`PCW_REG_CTRL] <= `PCW_CTRL_RESET;
			s_q.regs[`PCW_REG_PREDIV] <= `PCW_PREDIV_RESET;
			s_q.pre_cnt <= 8'h00;
			s_q.lock_cnt <= 16'h0000;
			s_q.locked <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign phase_source_indicator_o = s_q.regs[`PCW_REG_CTRL][`PCW_CTRL_PHASE_REG_BIT]; // [R10]
	assign gate[0] = primary_out_gate_i; // [R8]
	// Secondary gates ignored while the outputs are not under port control
	assign gate[1] = secondary_a_gate_i | ~port_gate; // [R9]
	assign gate[2] = secondary_b_gate_i | ~port_gate; // [R9]
	assign gate[3] = secondary_c_gate_i | ~port_gate; // [R9]
	assign div_rst[0] = 1'b0;
	assign div_rst[1] = 1'b0;
	assign div_rst[2] = out_b_divider_reset_i; // [R4]
	assign div_rst[3] = out_c_divider_reset_i; // [R5]

	genvar g;
	generate
		for (g = 0; g < `PCW_NUM_OUTS; g++)
		begin : gen_out
			assign phase_sel[g] = phase_source_indicator_o ? s_q.regs[`PCW_REG_PHASE0 + g] : phase_port_i[g];
			pcw_out_div u_div (
				.clock_i(clock_i),
				.rst_b_i(rst_b_i),
				.run_i(run),
				.div_rst_i(div_rst[g]),
				.gate_i(gate[g]),
				.ratio_i(s_q.regs[`PCW_REG_DIV0 + g]),
				.phase_i(phase_sel[g]), // [R7]
				.clk_o(clk_out[g])
			);
		end
	endgenerate

	assign primary_out_clock_o = clk_out[0];
	assign secondary_out_clock_a_o = clk_out[1];
	assign secondary_out_clock_b_o = clk_out[2];
	assign secondary_out_clock_c_o = clk_out[3];
	assign lock_o = s_q.locked;
	assign settings_bus_ack_o = s_q.ack;
	assign settings_bus_rdata_o = s_q.rdata;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_lock_standby: assert property (standby_i |=> !lock_o) // [R6]
		else $error("lock high after standby");
	chk_lock_loop_reset: assert property (loop_reset_i |=> !lock_o) // [R2]
		else $error("lock high after loop reset");
	chk_prediv_kept: assert property ((loop_reset_i && !full_reset_with_prediv_i
		&& s_q.pre_cnt < s_q.regs[`PCW_REG_PREDIV]) |=> s_q.pre_cnt == $past(s_q.pre_cnt) + 8'h01) // [R2]
		else $error("pre-divider disturbed by loop reset");
	chk_prediv_cleared: assert property (full_reset_with_prediv_i |=> s_q.pre_cnt == 8'h00) // [R3]
		else $error("pre-divider not cleared");
	chk_primary_gate: assert property (!primary_out_gate_i |=> !primary_out_clock_o) // [R8]
		else $error("primary clock ran while gated");
	chk_out_b_reset: assert property (out_b_divider_reset_i |=> !secondary_out_clock_b_o) // [R4]
		else $error("output b ran in reset");
	chk_out_c_reset: assert property (out_c_divider_reset_i |=> !secondary_out_clock_c_o) // [R5]
		else $error("output c ran in reset");
	chk_standby_clocks: assert property (standby_i |=> !clk_out[0] && !clk_out[1] && !clk_out[2] && !clk_out[3]) // [R6]
		else $error("clock ran during standby");
	chk_bus_reset_regs: assert property (settings_bus_reset_i |=> s_q.regs == $past(s_q.regs)) // [R12]
		else $error("settings changed by bus reset");
	chk_ack_cause: assert property ($rose(settings_bus_ack_o) |-> $past(settings_bus_strobe_i)
		&& $past(bclk_rise)) // [R17]
		else $error("ack without strobe on bus clock edge");
	chk_ack_bound: assert property ((bclk_rise && s_q.bus == PCW_BUS_IDLE && settings_bus_strobe_i
		&& !settings_bus_reset_i) |=> settings_bus_ack_o) // [R11]
		else $error("ack missing after strobe");
	chk_lock_time: assert property ((rst_b_i && !standby_i && !loop_rst) [*8] // [R1]
		|-> s_q.lock_cnt >= 16'h0007 || lock_o)
		else $error("lock counter stalled");

	// Settings bus handshake
	chk_ack_hold: assert property ((settings_bus_ack_o && !bclk_rise && !settings_bus_reset_i) // [R17]
		|=> settings_bus_ack_o)
		else $error("ack dropped before the next bus clock rise");

	chk_ack_drop: assert property ((settings_bus_ack_o && bclk_rise && !settings_bus_reset_i) // [R17]
		|=> !settings_bus_ack_o)
		else $error("ack still high after a bus clock rise");

	chk_ack_state: assert property (settings_bus_ack_o // [R17]
		== (s_q.bus == PCW_BUS_ACK))
		else $error("ack out of step with bus state");

	chk_no_retake: assert property ((s_q.bus == PCW_BUS_DONE) // [R18]
		|=> !$rose(settings_bus_ack_o))
		else $error("access taken twice");

	// Bus reset
	chk_bus_reset_idle: assert property (settings_bus_reset_i // [R12]
		|=> !settings_bus_ack_o && s_q.bus == PCW_BUS_IDLE)
		else $error("bus not idle after bus reset");

	chk_bus_reset_rdata: assert property (settings_bus_reset_i // [R12]
		|=> $stable(settings_bus_rdata_o))
		else $error("read data changed by bus reset");

	// Read and write data
	chk_rdata_hold: assert property (!(bclk_rise && s_q.bus == PCW_BUS_IDLE && settings_bus_strobe_i) // [R17]
		|=> $stable(settings_bus_rdata_o))
		else $error("read data changed without an access");

	chk_write_lands: assert property ((bclk_rise && s_q.bus == PCW_BUS_IDLE && settings_bus_strobe_i // [R16]
		&& settings_bus_write_i && settings_bus_addr_i != `PCW_REG_STATUS && !settings_bus_reset_i)
		|=> s_q.regs[$past(settings_bus_addr_i)] == $past(settings_bus_wdata_i))
		else $error("write data not stored");

	chk_read_data: assert property ((bclk_rise && s_q.bus == PCW_BUS_IDLE && settings_bus_strobe_i // [R14]
		&& !settings_bus_write_i && settings_bus_addr_i != `PCW_REG_STATUS && !settings_bus_reset_i)
		|=> settings_bus_rdata_o == s_q.regs[$past(settings_bus_addr_i)])
		else $error("read data differs from stored value");

	chk_status_read: assert property ((bclk_rise && s_q.bus == PCW_BUS_IDLE && settings_bus_strobe_i // [R1]
		&& !settings_bus_write_i && settings_bus_addr_i == `PCW_REG_STATUS && !settings_bus_reset_i)
		|=> settings_bus_rdata_o == {6'h00, $past(standby_i), $past(lock_o)})
		else $error("status read wrong");

	// Output gating
	chk_out_a_gated: assert property ((port_gate && !secondary_a_gate_i) // [R9]
		|=> !secondary_out_clock_a_o)
		else $error("output a ran while gated");

	chk_out_b_gated: assert property ((port_gate && !secondary_b_gate_i) // [R9]
		|=> !secondary_out_clock_b_o)
		else $error("output b ran while gated");

	chk_out_c_gated: assert property ((port_gate && !secondary_c_gate_i) // [R9]
		|=> !secondary_out_clock_c_o)
		else $error("output c ran while gated");

	chk_clocks_unlocked: assert property (!lock_o |=> !primary_out_clock_o // [R6]
		&& !secondary_out_clock_a_o && !secondary_out_clock_b_o && !secondary_out_clock_c_o)
		else $error("clock ran while unlocked");

	// Lock and pre-divider
	chk_lock_full_reset: assert property (full_reset_with_prediv_i // [R3]
		|=> !lock_o)
		else $error("lock high after full reset");

	chk_lock_hold: assert property ((lock_o && !standby_i && !loop_rst) // [R1]
		|=> lock_o)
		else $error("lock lost without a reset");

	chk_lock_count_clear: assert property ((loop_rst || standby_i) // [R2]
		|=> s_q.lock_cnt == 16'h0000)
		else $error("lock counter not cleared");

	chk_prediv_wrap: assert property ((s_q.pre_cnt >= s_q.regs[`PCW_REG_PREDIV]) // [R2]
		|=> s_q.pre_cnt == 8'h00)
		else $error("pre-divider did not wrap");
endmodule
`default_nettype wire

// ===== testbench/pcw_user_model.sv
// User-side model: settings bus clock and bus accesses
`default_nettype none
module pcw_user_model (
	input wire logic clock_i,
	input wire logic ack_i,
	output logic bus_clk_o,
	output logic strobe_o,
	output logic write_o,
	output logic [4:0] addr_o,
	output pcw_pkg::pcw_byte_t wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import pcw_pkg::*;
	logic [2:0] div_q = 3'h0;
	always @(posedge clock_i)
		div_q <= div_q + 3'h1;
	assign bus_clk_o = div_q[2];
	initial
	begin
		strobe_o = 1'b0;
		write_o = 1'b0;
		addr_o = 5'h00;
		wdata_o = 8'h00;
	end
	task automatic access(input logic wr, input logic [4:0] a, input pcw_byte_t d, output logic ok);
		int n;
		int w;
		n = 0;
		w = 0;
		// Strobe rises while the bus clock is low, so the next rise takes it
		while (bus_clk_o && w < 16)
		begin
			@(posedge clock_i);
			w++;
		end
		strobe_o <= 1'b1;
		write_o <= wr;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clock_i);
		while (ack_i !== 1'b1 && n < 64)
		begin
			@(posedge clock_i);
			n++;
		end
		ok = n < 64 && w < 16;
		// Inverted lines after release, so stale values never pass
		strobe_o <= 1'b0;
		write_o <= ~wr;
		addr_o <= ~a;
		wdata_o <= ~d;
		// Ack falls and a strobe-low bus edge is seen in three bus periods
		repeat (24)
			@(posedge clock_i);
	endtask
endmodule
`default_nettype wire

// ===== testbench/pcw_top_test.sv
// Self-checking bench for the PLL control wrapper
`default_nettype none
module pcw_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pcw_pkg::*;
	logic clock_i, rst_b_i, loop_reset_i, full_reset_with_prediv_i, out_b_divider_reset_i, out_c_divider_reset_i;
	logic standby_i, primary_out_gate_i, secondary_a_gate_i, secondary_b_gate_i, secondary_c_gate_i;
	logic [3:0][7:0] phase_port_i;
	logic settings_bus_clock_i, settings_bus_reset_i, settings_bus_strobe_i, settings_bus_write_i;
	logic [4:0] settings_bus_addr_i, a;
	pcw_byte_t settings_bus_wdata_i, settings_bus_rdata_o, d;
	logic settings_bus_ack_o, lock_o, phase_source_indicator_o, primary_out_clock_o;
	logic secondary_out_clock_a_o, secondary_out_clock_b_o, secondary_out_clock_c_o;
	logic ack_prev = 1'b0;
	logic [3:0] outs;
	int fail_count = 0, check_count = 0, seed = 32'h54c3_9a58;
	pcw_byte_t exp_q[$];
	logic [15:0] tab[7] = '{16'h0001, 16'h0101, 16'h0201, 16'h0301, 16'h0802, 16'h0901, 16'h0a01};
	pcw_top #(.LOCK_CYCLES(8)) dut (.clock_i, .rst_b_i, .loop_reset_i, .full_reset_with_prediv_i,
		.out_b_divider_reset_i, .out_c_divider_reset_i, .standby_i, .primary_out_gate_i, .secondary_a_gate_i,
		.secondary_b_gate_i, .secondary_c_gate_i, .phase_port_i, .settings_bus_clock_i, .settings_bus_reset_i,
		.settings_bus_strobe_i, .settings_bus_write_i, .settings_bus_addr_i, .settings_bus_wdata_i,
		.settings_bus_rdata_o, .settings_bus_ack_o, .lock_o, .phase_source_indicator_o, .primary_out_clock_o,
		.secondary_out_clock_a_o, .secondary_out_clock_b_o, .secondary_out_clock_c_o);
	pcw_user_model u_user (.clock_i, .ack_i(settings_bus_ack_o), .bus_clk_o(settings_bus_clock_i),
		.strobe_o(settings_bus_strobe_i), .write_o(settings_bus_write_i), .addr_o(settings_bus_addr_i),
		.wdata_o(settings_bus_wdata_i));
	assign outs = {secondary_out_clock_c_o, secondary_out_clock_b_o, secondary_out_clock_a_o, primary_out_clock_o};
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	task automatic report_and_stop();
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input string what, input pcw_byte_t exp, input pcw_byte_t got);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// A running output is high some but not all of 40 cycles; a stopped one never
	task automatic run_chk(input int idx, input logic run);
		int n;
		n = 0;
		repeat (3)
			@(posedge clock_i);
		repeat (40)
		begin
			@(negedge clock_i);
			n += int'(outs[idx] === 1'b1);
		end
		cmp("clock activity", {7'h0, run}, {7'h0, run ? (n > 0 && n < 40) : (n > 0)});
		@(posedge clock_i);
	endtask
	// Output a starts one count ahead, so the primary trails it by one cycle
	task automatic phase_chk();
		int lag;
		int diff;
		logic prev;
		lag = 0;
		diff = 0;
		@(negedge clock_i);
		prev = outs[1];
		repeat (16)
		begin
			@(negedge clock_i);
			lag += int'(outs[0] !== prev);
			diff += int'(outs[0] !== outs[1]);
			prev = outs[1];
		end
		cmp("phase lag", 8'h00, 8'(lag));
		cmp("phase offset", 8'h01, {7'h0, diff > 0});
		@(posedge clock_i);
	endtask
	task automatic lock_rise();
		repeat (7)
			@(posedge clock_i);
		cmp("lock early", 8'h00, {7'h0, lock_o});
		repeat (5)
			@(posedge clock_i);
		cmp("lock", 8'h01, {7'h0, lock_o});
	endtask
	task automatic bus(input logic w, input logic [4:0] ad, input pcw_byte_t dt);
		logic ok;
		if (!w)
			exp_q.push_back(dt);
		u_user.access(w, ad, dt, ok);
		if (!ok)
		begin
			fail_count++;
			report_and_stop();
		end
	endtask
	always @(negedge clock_i)
	begin
		if (settings_bus_ack_o === 1'b1 && ack_prev !== 1'b1 && settings_bus_write_i === 1'b0)
			cmp("read data", exp_q.pop_front(), settings_bus_rdata_o);
		ack_prev = settings_bus_ack_o;
	end
	initial
	begin
		{rst_b_i, loop_reset_i, full_reset_with_prediv_i, out_b_divider_reset_i, out_c_divider_reset_i} = '0;
		{standby_i, settings_bus_reset_i} = 2'b00;
		{primary_out_gate_i, secondary_a_gate_i, secondary_b_gate_i, secondary_c_gate_i} = 4'hf;
		phase_port_i = 32'($random(seed));
		repeat (2)
			@(posedge clock_i);
		rst_b_i <= 1'b1;
		lock_rise();
		foreach (tab[i])
			bus(1'b0, tab[i][12:8], tab[i][7:0]);
		for (int i = 0; i < 6; i++)
		begin
			a = 5'(11 + {$random(seed)} % 21);
			d = 8'($random(seed));
			bus(1'b1, a, d);
			bus(1'b0, a, d);
		end
		bus(1'b1, 5'h0a, 8'hff);
		bus(1'b0, 5'h0a, 8'h01);
		bus(1'b1, 5'h1f, 8'h5a);
		settings_bus_reset_i <= 1'b1;
		@(posedge clock_i);
		settings_bus_reset_i <= 1'b0;
		bus(1'b0, 5'h1f, 8'h5a);
		cmp("phase source", 8'h00, {7'h0, phase_source_indicator_o});
		bus(1'b1, 5'h08, 8'h03);
		cmp("phase source", 8'h01, {7'h0, phase_source_indicator_o});
		primary_out_gate_i <= 1'b0;
		run_chk(0, 1'b0);
		primary_out_gate_i <= 1'b1;
		run_chk(0, 1'b1);
		{secondary_a_gate_i, secondary_b_gate_i, secondary_c_gate_i} <= 3'b000;
		run_chk(1, 1'b0);
		run_chk(3, 1'b0);
		bus(1'b1, 5'h08, 8'h00);
		run_chk(1, 1'b1);
		run_chk(2, 1'b1);
		{secondary_a_gate_i, secondary_b_gate_i, secondary_c_gate_i} <= 3'b111;
		bus(1'b1, 5'h08, 8'h02);
		out_b_divider_reset_i <= 1'b1;
		run_chk(2, 1'b0);
		run_chk(3, 1'b1);
		out_b_divider_reset_i <= 1'b0;
		out_c_divider_reset_i <= 1'b1;
		run_chk(3, 1'b0);
		run_chk(2, 1'b1);
		out_c_divider_reset_i <= 1'b0;
		bus(1'b1, 5'h08, 8'h03);
		bus(1'b1, 5'h05, 8'h01);
		for (int k = 0; k < 2; k++)
		begin
			{full_reset_with_prediv_i, loop_reset_i} <= k ? 2'b10 : 2'b01;
			repeat (3)
				@(posedge clock_i);
			cmp("lock in reset", 8'h00, {7'h0, lock_o});
			{full_reset_with_prediv_i, loop_reset_i} <= 2'b00;
			lock_rise();
			phase_chk();
		end
		standby_i <= 1'b1;
		for (int i = 0; i < 4; i++)
			run_chk(i, 1'b0);
		cmp("lock in standby", 8'h00, {7'h0, lock_o});
		bus(1'b0, 5'h0a, 8'h02);
		standby_i <= 1'b0;
		lock_rise();
		for (int i = 0; i < 4; i++)
			run_chk(i, 1'b1);
		cmp("reads pending", 8'h00, 8'(exp_q.size()));
		report_and_stop();
	end
endmodule
`default_nettype wire
